// ### hdl/serial_ctl_two_consts.vh
// Constants for the serial control two register block
`ifndef SERIAL_CTL_TWO_CONSTS_VH
`define SERIAL_CTL_TWO_CONSTS_VH
`define ADDR_CTL_TWO 4'h0
`define ADDR_CTL_ONE 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_MASK 4'h3
`define ADDR_RXDATA 4'h4
`define ADDR_TXDATA 4'h5
`define BIT_SIGN_EXT 15
`define BIT_FRM_EN 12
`define BIT_ROV_EN 11
`define BIT_TUR_EN 10
`define BIT_IGN_ROV 9
`define BIT_IGN_TUR 8
`define BIT_AUD_EN 7
`define BIT_MONO 3
`define BIT_ON 15
`define CTL_TWO_WMASK 32'h00009F8B
`define CTL_TWO_RESET 32'h00000000
`define MODE_I2S 2'h0
`define MODE_LEFT 2'h1
`define MODE_RIGHT 2'h2
`define MODE_PCM 2'h3
`define WORD_BITS 16
`define RX_DEPTH 4
`endif

// ### hdl/rx_word_store.v
// Small receive word store with registered read data
`timescale 1ns/1ps
module rx_word_store (
  // Clock
  input wire sys_clk,
  input wire clk_en,
  // Write side
  input wire wr_en,
  input wire [1:0] wr_addr,
  input wire [15:0] wr_data,
  // Read side
  input wire [1:0] rd_addr,
  output reg [15:0] rd_data_ff
);
  reg [15:0] mem [0:3];
  always @(posedge sys_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem[rd_addr];
    end
  end
endmodule // rx_word_store

// ### hdl/spi_audio_error_control.v
// Serial control two register with a simple audio serial engine
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module spi_audio_error_control (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rst,
  input wire clk_en,
  // Register port
  input wire [3:0] addr,
  input wire [31:0] wr_data,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rd_data_ff,
  // Error conditions from the serial unit
  input wire frame_error_flag,
  // Serial link
  input wire link_sck,
  input wire link_ws,
  input wire link_sdi,
  output reg link_sdo_ff,
  // Event outputs
  output reg error_event_ff,
  output reg irq_ff,
  output reg halted_ff
);
`include "serial_ctl_two_consts.vh"

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [31:0] ctl_two_ff;
  reg unit_on_ff;
  reg [2:0] status_ff;
  reg [2:0] mask_ff;
  reg [15:0] tx_buffer_ff;
  reg tx_full_ff;
  reg [1:0] wr_ptr_ff, rd_ptr_ff;
  reg [2:0] rx_count_ff;
  wire [31:0] ctl_wmask = `CTL_TWO_WMASK;

  wire [1:0] audio_mode_field = ctl_two_ff[1:0];
  wire audio_enable = ctl_two_ff[`BIT_AUD_EN];
  // Mono and framing are ignored unless audio is on
  wire mono_eff = audio_enable & ctl_two_ff[`BIT_MONO];
  wire [1:0] mode_eff = audio_enable ? audio_mode_field : `MODE_I2S;

  // ------------------------------------------------------------
  // Link input synchronisers
  // ------------------------------------------------------------
  reg [1:0] sck_s_ff, ws_s_ff, sdi_s_ff;
  reg sck_d_ff, ws_d_ff;
  always @(posedge sys_clk) begin
    if (rst) begin
      sck_s_ff <= 2'h0;
      ws_s_ff <= 2'h0;
      sdi_s_ff <= 2'h0;
      sck_d_ff <= 1'b0;
      ws_d_ff <= 1'b0;
    end else if (clk_en) begin
      sck_s_ff <= {sck_s_ff[0], link_sck};
      ws_s_ff <= {ws_s_ff[0], link_ws};
      sdi_s_ff <= {sdi_s_ff[0], link_sdi};
      sck_d_ff <= sck_s_ff[1];
      ws_d_ff <= ws_s_ff[1];
    end
  end
  wire sck_rise = sck_s_ff[1] & ~sck_d_ff;
  wire sck_fall = ~sck_s_ff[1] & sck_d_ff;
  wire ws_edge = ws_s_ff[1] ^ ws_d_ff;
  // PCM frames start on the rising edge of the sync only
  wire frame_start = (mode_eff == `MODE_PCM) ?
    (ws_s_ff[1] & ~ws_d_ff) : ws_edge;
  // I2S delays the word one bit after the select edge
  wire one_bit_delay = audio_enable & (mode_eff == `MODE_I2S);

  // ------------------------------------------------------------
  // Serial engine
  // ------------------------------------------------------------
  wire running = unit_on_ff & ~halted_ff;
  // Switching off clears a halt at once, so the next write sees it gone
  wire unit_off_wr = wr_stb & (addr == `ADDR_CTL_ONE) & ~wr_data[`BIT_ON];
  reg [15:0] tx_shift_ff, rx_shift_ff;
  reg [4:0] bit_cnt_ff;
  reg pend_ff;
  reg second_ch_ff;
  reg [15:0] mono_word_ff;
  reg word_done;
  reg underrun_now;
  reg [15:0] load_word;
  always @* begin
    word_done = running & sck_rise & (bit_cnt_ff == 5'd15);
    underrun_now = 1'b0;
    load_word = 16'h0000;
    if (mono_eff && second_ch_ff) begin
      load_word = mono_word_ff;
    end else if (tx_full_ff) begin
      load_word = tx_buffer_ff;
    end else begin
      underrun_now = 1'b1;
      load_word = 16'h0000;
    end
  end
  // With the one-bit delay the select edge only arms the load; counting it
  // as a load would flag a false underrun and drop a buffered word
  wire load_now = running & sck_fall &
    (pend_ff | (frame_start & ~one_bit_delay));
  wire tur_event = load_now & underrun_now;
  wire rx_full = (rx_count_ff == 3'd4);
  wire rov_event = word_done & rx_full;
  wire rx_push = word_done & ~rx_full;
  wire rx_pop = rd_stb & (addr == `ADDR_RXDATA) & (rx_count_ff != 3'd0);
  wire [15:0] rx_word = {rx_shift_ff[14:0], sdi_s_ff[1]};

  always @(posedge sys_clk) begin
    if (rst) begin
      tx_shift_ff <= 16'h0000;
      rx_shift_ff <= 16'h0000;
      bit_cnt_ff <= 5'd0;
      pend_ff <= 1'b0;
      second_ch_ff <= 1'b0;
      mono_word_ff <= 16'h0000;
      link_sdo_ff <= 1'b0;
      halted_ff <= 1'b0;
    end else if (clk_en) begin
      if (!unit_on_ff || unit_off_wr) begin
        halted_ff <= 1'b0;
        bit_cnt_ff <= 5'd0;
        pend_ff <= 1'b0;
        link_sdo_ff <= 1'b0;
      end else if (running) begin
        if (sck_fall && frame_start && one_bit_delay && !pend_ff) begin
          pend_ff <= 1'b1;
        end else if (load_now) begin
          pend_ff <= 1'b0;
          tx_shift_ff <= {load_word[14:0], 1'b0};
          link_sdo_ff <= load_word[15];
          bit_cnt_ff <= 5'd0;
          second_ch_ff <= ~second_ch_ff;
          if (!second_ch_ff) begin
            mono_word_ff <= load_word;
          end
        end else if (sck_fall) begin
          link_sdo_ff <= tx_shift_ff[15];
          tx_shift_ff <= {tx_shift_ff[14:0], 1'b0};
        end
        if (sck_rise) begin
          rx_shift_ff <= rx_word;
          bit_cnt_ff <= (bit_cnt_ff == 5'd15) ? 5'd0 : bit_cnt_ff + 5'd1;
        end
        if (rov_event && !ctl_two_ff[`BIT_IGN_ROV]) begin
          halted_ff <= 1'b1;
        end
        if (tur_event && !ctl_two_ff[`BIT_IGN_TUR]) begin
          halted_ff <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Receive store
  // ------------------------------------------------------------
  wire [15:0] rx_head;
  // Address the store one pop ahead so its registered output already holds
  // the head word when a read arrives; a word pushed into an empty store
  // shows one cycle later
  wire [1:0] rd_next = rx_pop ? rd_ptr_ff + 2'h1 : rd_ptr_ff;
  rx_word_store u_store (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .wr_en(rx_push),
    .wr_addr(wr_ptr_ff),
    .wr_data(rx_word),
    .rd_addr(rd_next),
    .rd_data_ff(rx_head)
  );
  // Sign extension applied on the way out of the store
  wire [31:0] rx_read = ctl_two_ff[`BIT_SIGN_EXT] ?
    {{16{rx_head[15]}}, rx_head} : {16'h0000, rx_head};

  // ------------------------------------------------------------
  // Error events
  // ------------------------------------------------------------
  wire [2:0] ev_raw = {frame_error_flag & ctl_two_ff[`BIT_FRM_EN],
    rov_event & ctl_two_ff[`BIT_ROV_EN],
    tur_event & ctl_two_ff[`BIT_TUR_EN]};
  wire status_rd = rd_stb & (addr == `ADDR_STATUS);

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  reg [31:0] nxt_rd;
  always @* begin
    nxt_rd = 32'h00000000;
    if (addr == `ADDR_CTL_TWO) begin
      nxt_rd = ctl_two_ff & `CTL_TWO_WMASK;
    end else if (addr == `ADDR_CTL_ONE) begin
      nxt_rd = {16'h0000, unit_on_ff, 15'h0000};
    end else if (addr == `ADDR_STATUS) begin
      nxt_rd = {27'h0, rx_count_ff == 3'd0, halted_ff, status_ff};
    end else if (addr == `ADDR_MASK) begin
      nxt_rd = {29'h0, mask_ff};
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ctl_two_ff <= `CTL_TWO_RESET;
      unit_on_ff <= 1'b0;
      status_ff <= 3'h0;
      mask_ff <= 3'h0;
      tx_buffer_ff <= 16'h0000;
      tx_full_ff <= 1'b0;
      wr_ptr_ff <= 2'h0;
      rd_ptr_ff <= 2'h0;
      rx_count_ff <= 3'h0;
      rd_data_ff <= 32'h00000000;
      error_event_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      error_event_ff <= |ev_raw;
      // A new event wins over the read that clears it
      status_ff <= (status_rd ? 3'h0 : status_ff) | ev_raw;
      irq_ff <= |(((status_rd ? 3'h0 : status_ff) | ev_raw) & mask_ff);
      if (rd_stb && addr == `ADDR_RXDATA) begin
        rd_data_ff <= rx_read;
      end else begin
        rd_data_ff <= nxt_rd;
      end
      if (wr_stb) begin
        if (addr == `ADDR_CTL_TWO) begin
          ctl_two_ff[15:8] <= wr_data[15:8] & ctl_wmask[15:8];
          if (!unit_on_ff) begin
            ctl_two_ff[7:0] <= wr_data[7:0] & ctl_wmask[7:0];
          end
        end else if (addr == `ADDR_CTL_ONE) begin
          unit_on_ff <= wr_data[`BIT_ON];
        end else if (addr == `ADDR_MASK) begin
          mask_ff <= wr_data[2:0];
        end else if (addr == `ADDR_TXDATA) begin
          tx_buffer_ff <= wr_data[15:0];
          tx_full_ff <= 1'b1;
        end
      end else if (load_now && !(mono_eff && second_ch_ff) && tx_full_ff) begin
        tx_full_ff <= 1'b0;
      end
      if (rx_push) begin
        wr_ptr_ff <= wr_ptr_ff + 2'h1;
      end
      if (rx_pop) begin
        rd_ptr_ff <= rd_ptr_ff + 2'h1;
      end
      rx_count_ff <= rx_count_ff + {2'h0, rx_push} - {2'h0, rx_pop};
    end
  end

endmodule // spi_audio_error_control

// ### sim/spi_audio_error_control_chk.sv
// Port checker for the serial control two block
`timescale 1ns/1ps
`include "serial_ctl_two_consts.vh"
module spi_audio_error_control_chk (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rst,
  input wire clk_en,
  // Register port
  input wire [3:0] addr,
  input wire [31:0] wr_data,
  input wire wr_stb,
  input wire rd_stb,
  input wire [31:0] rd_data_ff,
  // Status and link
  input wire frame_error_flag,
  input wire link_sdo_ff,
  input wire error_event_ff,
  input wire irq_ff,
  input wire halted_ff
);
  // ----
  // Shadow of control two, with the lock while the unit is on
  // ----
  reg [31:0] ctl_ff;
  reg on_ff;
  wire [31:0] lock = on_ff ? 32'h0000008B : 32'h00000000;
  wire [31:0] nxt_ctl = (wr_data & `CTL_TWO_WMASK & ~lock) | (ctl_ff & lock);
  always @(posedge sys_clk) begin
    if (rst) begin
      ctl_ff <= 32'h00000000;
      on_ff <= 1'b0;
    end else if (clk_en && wr_stb) begin
      if (addr == `ADDR_CTL_TWO)
        ctl_ff <= nxt_ctl;
      if (addr == `ADDR_CTL_ONE)
        on_ff <= wr_data[`BIT_ON];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rst;
    disable iff (1'b0) rst |=> !irq_ff && !halted_ff && !error_event_ff;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs set after reset");
  property p_rd_ctl;
    rd_stb && clk_en && addr == `ADDR_CTL_TWO |=> rd_data_ff == $past(ctl_ff);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control two read");
  property p_sign;
    rd_stb && clk_en && addr == `ADDR_RXDATA |=>
      rd_data_ff[31:16] == (ctl_ff[15] ? {16{rd_data_ff[15]}} : 16'h0000);
  endproperty
  a_sign: assert property (p_sign) else $error("rx word extension");
  property p_frm_event;
    frame_error_flag && ctl_ff[12] |-> ##[1:3] error_event_ff;
  endproperty
  a_frm_event: assert property (p_frm_event) else $error("no frame event");
  property p_err_quiet;
    ctl_ff[12:10] == 3'h0 && $past(ctl_ff[12:10]) == 3'h0 |-> !error_event_ff;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("event while off");
  property p_halt_cause;
    $rose(halted_ff) |-> !(ctl_ff[9] && ctl_ff[8]);
  endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt ignored");
  property p_halt_clr;
    wr_stb && clk_en && addr == `ADDR_CTL_ONE && !wr_data[15] |=> !halted_ff;
  endproperty
  a_halt_clr: assert property (p_halt_clr) else $error("halt kept");
  // The bench never loads transmit data, so every slot is an underrun
  property p_ign_tur;
    ctl_ff[8] && $past(ctl_ff[8]) |-> !link_sdo_ff;
  endproperty
  a_ign_tur: assert property (p_ign_tur) else $error("underrun not zero");
endmodule // spi_audio_error_control_chk
bind spi_audio_error_control spi_audio_error_control_chk chk (
  .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .addr(addr),
  .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rd_data_ff(rd_data_ff), .frame_error_flag(frame_error_flag),
  .link_sdo_ff(link_sdo_ff), .error_event_ff(error_event_ff),
  .irq_ff(irq_ff), .halted_ff(halted_ff));

// ### sim/codec_model.sv
// Behavioural audio codec sending standard framed words
`timescale 1ns/1ps
module codec_model (
  // Control from the bench
  input wire start,
  input wire [3:0] count,
  // Link
  output reg link_sck,
  output reg link_ws,
  output reg link_sdi,
  output reg busy
);
  integer i;
  integer b;
  reg [15:0] w;
  initial begin
    link_sck = 1'b0;
    link_ws = 1'b1;
    link_sdi = 1'b0;
    busy = 1'b0;
  end
  // Clock stands low between frames; data moves on the falling edge
  always @(posedge start) begin
    busy = 1'b1;
    // Lead-in bit so the first select change falls on a clock fall
    #400 link_sck = 1'b1;
    #400 link_sck = 1'b0;
    for (i = 0; i < count; i = i + 1) begin
      w = 16'h8001 + 16'h1111 * i[15:0];
      link_ws = i[0];
      for (b = 15; b >= 0; b = b - 1) begin
        #400 link_sck = 1'b1;
        #400 link_sck = 1'b0;
        link_sdi = w[b];
      end
    end
    link_ws = ~link_ws;
    #400 link_sck = 1'b1;
    #400 link_sck = 1'b0;
    link_sdi = ~link_sdi; // Released line must not hold a stale bit
    busy = 1'b0;
  end
endmodule // codec_model

// ### sim/tb.sv
// Bench for the serial control two block
`timescale 1ns/1ps
`include "serial_ctl_two_consts.vh"
module tb;
  reg sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, wr_stb = 1'b0;
  reg rd_stb = 1'b0, frame_error_flag = 1'b0, start = 1'b0;
  reg ev_seen = 1'b0, sdo_seen = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wr_data = 32'h00000000;
  wire [31:0] rd_data;
  wire sck, ws, sdi, sdo, ev, irq, halted, busy;
  integer errors = 0, cmp_count = 0, cyc = 0, k;
  initial forever #50 sys_clk = ~sys_clk;
  spi_audio_error_control uut (.sys_clk(sys_clk), .rst(rst),
    .clk_en(clk_en), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data_ff(rd_data),
    .frame_error_flag(frame_error_flag), .link_sck(sck), .link_ws(ws),
    .link_sdi(sdi), .link_sdo_ff(sdo), .error_event_ff(ev), .irq_ff(irq),
    .halted_ff(halted));
  codec_model codec (.start(start), .count(4'h5), .link_sck(sck),
    .link_ws(ws), .link_sdi(sdi), .busy(busy));
  task test_done;
    begin
      $display("errors %0d cmp_count %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task chkb(input g, input e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1 chk(rd_data, e);
      @(posedge sys_clk);
    end
  endtask
  task pulse;
    begin
      frame_error_flag <= 1'b1;
      @(posedge sys_clk);
      frame_error_flag <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  task link;
    begin
      start <= 1'b1;
      repeat (2) @(posedge sys_clk);
      start <= 1'b0;
      while (busy) @(posedge sys_clk);
      repeat (20) @(posedge sys_clk);
    end
  endtask
  // Hang guard; a full run needs about 1500 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (ev) ev_seen <= 1'b1;
    if (sdo) sdo_seen <= 1'b1;
    if (cyc == 8000) begin
      errors = errors + 1;
      test_done;
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(`ADDR_CTL_TWO, 32'h0);
    wr(`ADDR_CTL_TWO, 32'hFFFFFFFF);
    wr(4'hE, 32'h0);
    rd(`ADDR_CTL_TWO, `CTL_TWO_WMASK);
    wr(`ADDR_CTL_ONE, 32'h8000);
    wr(`ADDR_CTL_TWO, 32'h0);
    rd(`ADDR_CTL_TWO, 32'h8B);
    wr(`ADDR_CTL_ONE, 32'h0);
    for (k = 0; k < 4; k = k + 1) begin
      wr(`ADDR_CTL_TWO, 32'h88 | k);
      rd(`ADDR_CTL_TWO, 32'h88 | k);
    end
    wr(`ADDR_MASK, 32'h7);
    wr(`ADDR_CTL_TWO, 32'h1000);
    pulse;
    chkb(irq, 1'b1);
    rd(`ADDR_STATUS, 32'h14);
    wr(`ADDR_MASK, 32'h0);
    pulse;
    chkb(irq, 1'b0);
    rd(`ADDR_STATUS, 32'h14);
    wr(`ADDR_CTL_TWO, 32'h0);
    pulse;
    rd(`ADDR_STATUS, 32'h10);
    wr(`ADDR_CTL_TWO, 32'h8380);
    wr(`ADDR_CTL_ONE, 32'h8000);
    link;
    chkb(halted, 1'b0);
    chkb(sdo_seen, 1'b0);
    rd(`ADDR_RXDATA, 32'hFFFF8001);
    rd(`ADDR_RXDATA, 32'hFFFF9112);
    wr(`ADDR_CTL_TWO, 32'h0380);
    rd(`ADDR_RXDATA, 32'h0000A223);
    rd(`ADDR_RXDATA, 32'h0000B334);
    wr(`ADDR_CTL_ONE, 32'h0);
    wr(`ADDR_CTL_TWO, 32'h0C80);
    wr(`ADDR_CTL_ONE, 32'h8000);
    ev_seen = 1'b0;
    link;
    chkb(halted, 1'b1);
    chkb(ev_seen, 1'b1);
    wr(`ADDR_CTL_ONE, 32'h0);
    chkb(halted, 1'b0);
    test_done;
  end
endmodule // tb
